// ---- tsf_pkg.sv ----
/*
 Package for the asynchronous timer with spurious overflow flag: register offsets,
 field positions, reset values, timing counts and carrier types.
 Assumes a single 25 MHz APB clock; the instruction cycle equals one pclk period.
*/
package tsf_pkg;

   // Register byte offsets
   localparam logic [11:0] OFF_CTRL  = 12'h000;
   localparam logic [11:0] OFF_FLAG  = 12'h004;
   localparam logic [11:0] OFF_MASK  = 12'h008;
   localparam logic [11:0] OFF_HIGH  = 12'h00C;
   localparam logic [11:0] OFF_LOW   = 12'h010;
   localparam logic [11:0] OFF_GUARD = 12'h014;

   // Control field positions
   localparam int CTRL_RUN_BIT   = 0;
   localparam int CTRL_ASYNC_BIT = 1;
   localparam int CTRL_EXT_BIT   = 2;

   // Flag and mask layout: bit 0 is the timer overflow flag
   localparam int FLAG_W       = 1;
   localparam int FLAG_OVF_BIT = 0;

   localparam logic [15:0]       COUNT_RST = 16'h0000;
   localparam logic [15:0]       COUNT_MAX = 16'hFFFF;
   localparam logic [7:0]        BYTE_RST  = 8'h00;
   localparam logic [FLAG_W-1:0] FLAG_RST  = 1'h0;
   localparam logic [FLAG_W-1:0] MASK_RST  = 1'h0;
   localparam logic [31:0]       DATA_ZERO = 32'h0000_0000;

   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int SPUR_NEAR_NS  = 80;
   localparam int SPUR_NEAR_CYC = (SPUR_NEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int GUARD_EDGES   = 2;
   localparam int GUARD_TAIL_CYC = 2;

   typedef struct packed {
      logic ext_source;
      logic async_mode;
      logic run;
   } tsf_ctrl_t;

   localparam tsf_ctrl_t CTRL_RST = '{ext_source: 1'b0, async_mode: 1'b0, run: 1'b0};

   typedef struct packed {
      logic sync_edge;
      logic async_edge;
   } tsf_edge_t;

   typedef enum logic [3:0] {
      G_IDLE  = 4'b0001,
      G_NEAR  = 4'b0010,
      G_EDGES = 4'b0100,
      G_TAIL  = 4'b1000
   } tsf_guard_t;

endpackage

// ---- tsf_edge.sv ----
/*
 Rising-edge finder for the external count clock pin.
 Assumes the pin is synchronous to pclk; the sync path adds one stage to mimic
 resynchronisation to the instruction clock, the async path uses the pin sample alone.
*/
`timescale 1ns/1ns
module tsf_edge (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                external_count_clock,
   output tsf_pkg::tsf_edge_t       edges
);
   logic s0_r, s1_r, s2_r;
   logic s0_nxt, s1_nxt, s2_nxt;

   always_comb begin
      s0_nxt = external_count_clock;
      s1_nxt = s0_r;
      s2_nxt = s1_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s0_r <= 1'b0;
         s1_r <= 1'b0;
         s2_r <= 1'b0;
      end else begin
         s0_r <= s0_nxt;
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
      end
   end

   // Async edge is one cycle early; that lead is what opens the spurious window
   assign edges.async_edge = s0_r & ~s1_r;
   assign edges.sync_edge  = s1_r & ~s2_r;
endmodule

// ---- tsf_timer.sv ----
/*
 16-bit timer/counter with APB registers, synchronous and asynchronous external
 count modes, and the spurious overflow flag seen in asynchronous mode.
 Assumes an APB master on pclk and an external count clock sampled on pclk.
*/
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns

module tsf_timer #(
   parameter int ADDR_W = 12
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              external_count_clock,
   output logic                   irq
);
   tsf_pkg::tsf_edge_t  edges;
   tsf_pkg::tsf_ctrl_t  ctrl_r, ctrl_nxt;
   tsf_pkg::tsf_guard_t guard_r, guard_nxt;

   logic [15:0]               cnt_r, cnt_nxt;
   logic [7:0]                hi_buf_r, hi_buf_nxt;
   logic [tsf_pkg::FLAG_W-1:0] flag_r, flag_nxt;
   logic [tsf_pkg::FLAG_W-1:0] mask_r, mask_nxt;
   logic [2:0]                gcnt_r, gcnt_nxt;
   logic [1:0]                gedge_r, gedge_nxt;
   logic [31:0]               prdata_r, prdata_nxt;
   logic                      pready_r, pready_nxt;
   logic                      pslverr_r, pslverr_nxt;
   logic                      irq_r, irq_nxt;

   logic capture, done, wr, rd;
   logic hit_ctrl, hit_flag, hit_mask, hit_high, hit_low, hit_guard, mapped;
   logic inc, ovf, cnt_write, arm, spurious, async_ext;
   logic [1:0] gedge_inc;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
      hit = (a[11:0] == off);
   endfunction

   function automatic logic [31:0] byte_word(input logic [7:0] b);
      byte_word = {24'h00_0000, b};
   endfunction

   // Guard counters step down the same way in the near and tail phases
   function automatic logic [2:0] tick_down(input logic [2:0] c);
      tick_down = c - 3'h1;
   endfunction

   function automatic logic last_tick(input logic [2:0] c);
      last_tick = (c == 3'h1);
   endfunction

   function automatic logic rises(input logic now_v, input logic was_v);
      rises = now_v & ~was_v;
   endfunction

   // Guard status as software sees it: bit 0 window open, bit 1 near phase
   function automatic logic [31:0] guard_word(input tsf_pkg::tsf_guard_t g);
      guard_word    = tsf_pkg::DATA_ZERO;
      guard_word[0] = (g != tsf_pkg::G_IDLE);
      guard_word[1] = (g == tsf_pkg::G_NEAR);
   endfunction

   // Edge finder: the async path leads the sync path by one clock
   tsf_edge tsf_edge_i (
      .pclk                 (pclk),
      .presetn              (presetn),
      .external_count_clock (external_count_clock),
      .edges                (edges)
   );

   // Bus decode: one wait cycle so that read data can come from a flop
   always_comb begin
      capture   = psel & penable & ~pready_r;
      done      = psel & penable & pready_r;
      wr        = done & pwrite;
      rd        = done & ~pwrite;
      hit_ctrl  = hit(paddr, tsf_pkg::OFF_CTRL);
      hit_flag  = hit(paddr, tsf_pkg::OFF_FLAG);
      hit_mask  = hit(paddr, tsf_pkg::OFF_MASK);
      hit_high  = hit(paddr, tsf_pkg::OFF_HIGH);
      hit_low   = hit(paddr, tsf_pkg::OFF_LOW);
      hit_guard = hit(paddr, tsf_pkg::OFF_GUARD);
      mapped    = hit_ctrl | hit_flag | hit_mask | hit_high | hit_low | hit_guard;
   end

   // Reads have no side effect on count or guard state
   always_comb begin
      pready_nxt  = capture;
      pslverr_nxt = capture & ~mapped;
      prdata_nxt  = tsf_pkg::DATA_ZERO;
      if (capture && !pwrite) begin
         if (hit_ctrl) begin
            prdata_nxt[tsf_pkg::CTRL_RUN_BIT]   = ctrl_r.run;
            prdata_nxt[tsf_pkg::CTRL_ASYNC_BIT] = ctrl_r.async_mode;
            prdata_nxt[tsf_pkg::CTRL_EXT_BIT]   = ctrl_r.ext_source;
         end else if (hit_flag) begin
            prdata_nxt[tsf_pkg::FLAG_W-1:0] = flag_r;
         end else if (hit_mask) begin
            prdata_nxt[tsf_pkg::FLAG_W-1:0] = mask_r;
         end else if (hit_high) begin
            prdata_nxt = byte_word(cnt_r[15:8]);
         end else if (hit_low) begin
            prdata_nxt = byte_word(cnt_r[7:0]);
         end else if (hit_guard) begin
            prdata_nxt = guard_word(guard_r);
         end else begin
            prdata_nxt = tsf_pkg::DATA_ZERO;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= tsf_pkg::DATA_ZERO;
      end else begin
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r  <= prdata_nxt;
      end
   end

   // Control and mask registers
   always_comb begin
      ctrl_nxt = ctrl_r;
      mask_nxt = mask_r;
      if (wr && hit_ctrl) begin
         ctrl_nxt.run        = pwdata[tsf_pkg::CTRL_RUN_BIT];
         ctrl_nxt.async_mode = pwdata[tsf_pkg::CTRL_ASYNC_BIT];
         ctrl_nxt.ext_source = pwdata[tsf_pkg::CTRL_EXT_BIT];
      end
      if (wr && hit_mask) begin
         mask_nxt = pwdata[tsf_pkg::FLAG_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= tsf_pkg::CTRL_RST;
         mask_r <= tsf_pkg::MASK_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
         mask_r <= mask_nxt;
      end
   end

   // Counter: high byte waits in a buffer so both bytes land together
   always_comb begin
      async_ext = ctrl_r.async_mode & ctrl_r.ext_source;
      // Internal source counts every clock and has no spurious path
      if (!ctrl_r.ext_source) begin
         inc = ctrl_r.run;
      end else if (ctrl_r.async_mode) begin
         inc = ctrl_r.run & edges.async_edge;
      end else begin
         inc = ctrl_r.run & edges.sync_edge;
      end
      hi_buf_nxt = hi_buf_r;
      cnt_nxt    = cnt_r;
      cnt_write  = wr & hit_low;
      ovf        = 1'b0;
      // A high write alone leaves the count alone; the low write commits both
      if (wr && hit_high) begin
         hi_buf_nxt = pwdata[7:0];
      end
      // A write beats a same-cycle increment; that lost edge is the hazard behind the flag
      if (cnt_write) begin
         cnt_nxt = {hi_buf_r, pwdata[7:0]};
      end else if (inc) begin
         cnt_nxt = cnt_r + 16'h0001;
         ovf     = (cnt_r == tsf_pkg::COUNT_MAX);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r    <= tsf_pkg::COUNT_RST;
         hi_buf_r <= tsf_pkg::BYTE_RST;
      end else begin
         cnt_r    <= cnt_nxt;
         hi_buf_r <= hi_buf_nxt;
      end
   end

   // Guard window after a low-byte count write, enable or switch to async mode
   always_comb begin
      arm = ctrl_nxt.async_mode & ctrl_nxt.ext_source &
            (cnt_write |
             rises(ctrl_nxt.run, ctrl_r.run) |
             rises(ctrl_nxt.async_mode, ctrl_r.async_mode));
      gedge_inc = gedge_r;
      if (inc && gedge_r != 2'(tsf_pkg::GUARD_EDGES)) begin
         gedge_inc = gedge_r + 2'h1;
      end
      guard_nxt = guard_r;
      gcnt_nxt  = gcnt_r;
      gedge_nxt = gedge_r;
      spurious  = 1'b0;
      // Leaving async or external mode shuts the window at once
      if (!async_ext) begin
         guard_nxt = tsf_pkg::G_IDLE;
      end else begin
         case (guard_r)
            tsf_pkg::G_IDLE: begin
               guard_nxt = tsf_pkg::G_IDLE;
            end
            tsf_pkg::G_NEAR: begin
               spurious  = inc;
               gedge_nxt = gedge_inc;
               gcnt_nxt  = tick_down(gcnt_r);
               if (last_tick(gcnt_r)) begin
                  guard_nxt = tsf_pkg::G_EDGES;
               end
            end
            tsf_pkg::G_EDGES: begin
               gedge_nxt = gedge_inc;
               if (gedge_inc == 2'(tsf_pkg::GUARD_EDGES)) begin
                  guard_nxt = tsf_pkg::G_TAIL;
                  gcnt_nxt  = 3'(tsf_pkg::GUARD_TAIL_CYC);
               end
            end
            tsf_pkg::G_TAIL: begin
               gcnt_nxt = tick_down(gcnt_r);
               if (last_tick(gcnt_r)) begin
                  guard_nxt = tsf_pkg::G_IDLE;
               end
            end
            default: begin
               guard_nxt = tsf_pkg::G_IDLE;
            end
         endcase
      end
      // Arming wins, so a fresh write restarts a window that is still open
      if (arm) begin
         guard_nxt = tsf_pkg::G_NEAR;
         gcnt_nxt  = 3'(tsf_pkg::SPUR_NEAR_CYC);
         gedge_nxt = 2'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         guard_r <= tsf_pkg::G_IDLE;
         gcnt_r  <= 3'h0;
         gedge_r <= 2'h0;
      end else begin
         guard_r <= guard_nxt;
         gcnt_r  <= gcnt_nxt;
         gedge_r <= gedge_nxt;
      end
   end

   // Flag: sticky, cleared by a read of the flag register, set wins over clear.
   // Only bits returned by that read are cleared, so nothing set meanwhile is lost.
   always_comb begin
      flag_nxt = flag_r;
      if (rd && hit_flag) begin
         flag_nxt = flag_r & ~prdata_r[tsf_pkg::FLAG_W-1:0];
      end
      // Count byte reads feed nothing here, so they cannot set the flag
      if (ovf || spurious) begin
         flag_nxt[tsf_pkg::FLAG_OVF_BIT] = 1'b1;
      end
      // Irq follows the next flag value, so it rises on the same edge as the flag
      irq_nxt = |(flag_nxt & mask_nxt);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_r <= tsf_pkg::FLAG_RST;
         irq_r  <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
         irq_r  <= irq_nxt;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;
   assign irq     = irq_r;
endmodule

// ---- tsf_ext_src.sv ----
/*
 Model of the external count clock source on the timer pin.
 Assumes pclk from the bench; the pin moves on pclk edges, as the timer expects.
*/
`timescale 1ns/1ns
module tsf_ext_src (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       enable,
   input  wire logic [3:0] half,
   output logic            external_count_clock
);
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic       pin_nxt;
   // Pin parks low between bursts so no stray edge is ever counted
   always_comb begin
      cnt_nxt = cnt_r + 4'h1;
      pin_nxt = external_count_clock;
      if (!enable) begin
         cnt_nxt = 4'h0;
         pin_nxt = 1'b0;
      end else if (cnt_nxt >= half) begin
         cnt_nxt = 4'h0;
         pin_nxt = !external_count_clock;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
         external_count_clock <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         external_count_clock <= pin_nxt;
      end
   end
endmodule

// ---- tsf_timer_asserts.sv ----
/*
 Port checker for the timer block.
 Assumes it is bound to tsf_timer; control and mask are shadowed from APB writes.
*/
`timescale 1ns/1ns
module tsf_timer_asserts #(
   parameter int ADDR_W = 12
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              external_count_clock,
   input wire logic              irq
);
   tsf_pkg::tsf_ctrl_t ctrl_r;
   tsf_pkg::tsf_ctrl_t ctrl_nxt;
   logic               mask_r;
   logic               mask_nxt;
   logic               wr_done;
   assign wr_done = psel && penable && pready && pwrite;
   always_comb begin
      ctrl_nxt = ctrl_r;
      mask_nxt = mask_r;
      if (wr_done && paddr == ADDR_W'(tsf_pkg::OFF_CTRL)) begin
         ctrl_nxt = pwdata[2:0];
      end
      if (wr_done && paddr == ADDR_W'(tsf_pkg::OFF_MASK)) begin
         mask_nxt = pwdata[0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= tsf_pkg::CTRL_RST;
         mask_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         mask_r <= mask_nxt;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence acc_s;
      psel && penable && !pready;
   endsequence
   sequence rd_s;
      pready && !pwrite;
   endsequence
   wait_one_a: assert property (acc_s |=> pready) else $error("pready late");
   pulse_one_a: assert property (pready |=> !pready) else $error("pready held");
   in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
   err_ready_a: assert property (pslverr |-> pready) else $error("pslverr alone");
   unmapped_a: assert property (rd_s ##0 paddr > ADDR_W'(tsf_pkg::OFF_GUARD)
      |-> pslverr && prdata == tsf_pkg::DATA_ZERO) else $error("unmapped read");
   idle_data_a: assert property (!pready |-> prdata == tsf_pkg::DATA_ZERO) else $error("prdata idle");
   mask_irq_a: assert property (!mask_r && !$past(mask_r) |-> !irq) else $error("irq while masked");
   sync_guard_a: assert property (rd_s ##0 paddr == ADDR_W'(tsf_pkg::OFF_GUARD)
      ##0 !(ctrl_r.async_mode && ctrl_r.ext_source) |-> !prdata[0]) else $error("window in sync");
endmodule
bind tsf_timer tsf_timer_asserts #(.ADDR_W(ADDR_W)) tsf_timer_asserts_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .external_count_clock(external_count_clock), .irq(irq));

// ---- testbench.sv ----
/*
 Self-checking bench for the timer: APB tasks, count source model, scenarios.
 Assumes tsf_timer, tsf_ext_src and the checker are compiled before it.
*/
`timescale 1ns/1ns
module testbench;
   logic        pclk, presetn, psel, penable, pwrite, src_en, pready, pslverr, ext_clk, irq, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] e;
   logic [3:0]  half;
   int          n_errors, check_count, n_edge, i;
   tsf_timer tsf_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_count_clock(ext_clk), .irq(irq));
   tsf_ext_src tsf_ext_src_i (.pclk(pclk), .presetn(presetn), .enable(src_en), .half(half),
      .external_count_clock(ext_clk));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge ext_clk) n_edge++;
   task complete_run;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask
   // Request held until pready is sampled, then released on that edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         n_errors++;
         complete_run;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task chkr(input string nm, input logic [11:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk(nm, ex, rd);
   endtask
   task pulse(input int cyc);
      src_en <= 1'b1;
      repeat (cyc) @(posedge pclk);
      src_en <= 1'b0;
      repeat (8) @(posedge pclk);
   endtask
   initial begin
      {psel, penable, pwrite, src_en, presetn} = 5'h0;
      paddr = 12'h000; pwdata = 32'h0; half = 4'h2;
      n_errors = 0; check_count = 0; n_edge = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 7; i++) chkr("reset", 12'(i * 4), 32'h0);
      chk("slverr", 32'h1, {31'h0, err});
      $display("test reset done");
      apb(1'b1, tsf_pkg::OFF_HIGH, 32'h12);
      apb(1'b1, tsf_pkg::OFF_LOW, 32'h34);
      chkr("high", tsf_pkg::OFF_HIGH, 32'h12);
      chkr("low", tsf_pkg::OFF_LOW, 32'h34);
      apb(1'b1, tsf_pkg::OFF_CTRL, 32'h5);
      n_edge = 0;
      pulse(40);
      e = 16'h1234 + 16'(n_edge);
      chkr("low", tsf_pkg::OFF_LOW, {24'h0, e[7:0]});
      chkr("high", tsf_pkg::OFF_HIGH, {24'h0, e[15:8]});
      // A count write with edges arriving must not flag in sync mode
      half <= 4'h1;
      src_en <= 1'b1;
      apb(1'b1, tsf_pkg::OFF_LOW, 32'h34);
      pulse(2);
      chkr("flag", tsf_pkg::OFF_FLAG, 32'h0);
      chkr("guard", tsf_pkg::OFF_GUARD, 32'h0);
      $display("test sync count done");
      apb(1'b1, tsf_pkg::OFF_CTRL, 32'h4);
      apb(1'b1, tsf_pkg::OFF_HIGH, 32'hFF);
      apb(1'b1, tsf_pkg::OFF_LOW, 32'hFE);
      apb(1'b1, tsf_pkg::OFF_CTRL, 32'h5);
      half <= 4'h1;
      n_edge = 0;
      pulse(12);
      e = 16'hFFFE + 16'(n_edge);
      chkr("wrap", tsf_pkg::OFF_LOW, {24'h0, e[7:0]});
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'b1, tsf_pkg::OFF_MASK, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h1, {31'h0, irq});
      chkr("flag", tsf_pkg::OFF_FLAG, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq", 32'h0, {31'h0, irq});
      chkr("flag", tsf_pkg::OFF_FLAG, 32'h0);
      $display("test overflow done");
      apb(1'b1, tsf_pkg::OFF_MASK, 32'h0);
      // Edges run while switching to async, so the window armed by that switch must catch one
      src_en <= 1'b1;
      apb(1'b1, tsf_pkg::OFF_CTRL, 32'h7);
      chkr("flag", tsf_pkg::OFF_FLAG, 32'h1);
      apb(1'b1, tsf_pkg::OFF_LOW, 32'h0);
      pulse(2);
      chk("irq", 32'h0, {31'h0, irq});
      chkr("flag", tsf_pkg::OFF_FLAG, 32'h1);
      chkr("high", tsf_pkg::OFF_HIGH, 32'hFF);
      $display("test spurious done");
      apb(1'b1, tsf_pkg::OFF_CTRL, 32'h6);
      apb(1'b1, tsf_pkg::OFF_HIGH, 32'h0);
      apb(1'b1, tsf_pkg::OFF_LOW, 32'h0);
      apb(1'b1, tsf_pkg::OFF_CTRL, 32'h7);
      apb(1'b0, tsf_pkg::OFF_GUARD, 32'h0);
      chk("guard", 32'h1, rd & 32'h1);
      half <= 4'h2;
      n_edge = 0;
      src_en <= 1'b1;
      for (i = 0; i < 50; i++) begin
         apb(1'b0, tsf_pkg::OFF_LOW, 32'h0);
         if (rd >= 32'h2) break;
      end
      if (i == 50) begin
         n_errors++;
         complete_run;
      end
      repeat (2) @(posedge pclk);
      apb(1'b0, tsf_pkg::OFF_FLAG, 32'h0);
      chkr("guard", tsf_pkg::OFF_GUARD, 32'h0);
      apb(1'b1, tsf_pkg::OFF_MASK, 32'h1);
      for (i = 0; i < 6; i++) apb(1'b0, tsf_pkg::OFF_HIGH, 32'h0);
      pulse(20);
      chkr("flag", tsf_pkg::OFF_FLAG, 32'h0);
      chk("irq", 32'h0, {31'h0, irq});
      chkr("low", tsf_pkg::OFF_LOW, 32'(n_edge));
      $display("test guard done");
      complete_run;
   end
endmodule
